/* core/csw_config.sv */
// selective wake configuration and status registers with receive path control
`timescale 1ns/10ps
`include "csw_defs.svh"

// What this block does
// - four 8-bit read/write payload byte registers
// - payload bytes 3..0 at 0x30..0x33
// - payload bytes clear on power-on or soft reset
// - fd control at 0x34, bits 7:6 read zero
// - disable bit stops error counter during selective wake when fd enabled
// - silence timeout clears the error counter disable
// - bypass bit routes receive around analog filter
// - digital dominant filter is never bypassed
// - filter code selects 50..300 ns or 700 ns
// - bit 0 enables fd tolerant mode
// - restart blocks writes to fd bits 5:0
// - trim at 0x38, bits 6:0 writable when key 11
// - options bit 7 picks wake receiver, key-guarded
// - options reset clears bits 7 and 4:0, restart keeps them; bits 6:5 read zero
// - read-only calibration high byte at 0x3a
module csw_config #(
  parameter int CNT_W = 8
) (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire logic                    soft_reset,
  input  wire logic                    restart,
  input  wire logic                    reg_wr_en,
  input  wire logic                    reg_rd_en,
  input  wire csw_pkg::csw_addr_t      reg_addr,
  input  wire csw_pkg::csw_byte_t      reg_wdata,
  output csw_pkg::csw_byte_t           reg_rdata,
  output logic                         reg_rd_valid,
  input  wire logic [1:0]              trim_enable,
  input  wire logic                    silence_timeout,
  input  wire logic                    selective_wake_active,
  input  wire csw_pkg::csw_byte_t      osc_cal_high_in,
  input  wire logic                    rx_raw,
  input  wire logic                    rx_analog_filtered,
  output logic                         rx_out,
  output csw_pkg::csw_byte_t           payload_byte_three,
  output csw_pkg::csw_byte_t           payload_byte_two,
  output csw_pkg::csw_byte_t           payload_byte_one,
  output csw_pkg::csw_byte_t           payload_byte_zero,
  output logic                         fd_tolerant_enable,
  output logic                         error_counter_disable,
  output logic                         error_counter_run,
  output logic                         analog_rx_filter_bypass,
  output csw_pkg::csw_filt_code_t      dominant_filter_time,
  output logic [CNT_W-1:0]             dominant_filter_cycles,
  output logic [6:0]                   oscillator_trim_value,
  output logic                         wake_receiver_select
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // all of them are constant or pure, so each may serve elaboration as well

  // least time in cycles, rounded up, never below one
  // rounding up keeps every filter at least as long as its nominal time
  function automatic int ns_to_cycles(input int ns);
    int cyc;
    cyc = (ns * `CSW_CLK_MHZ + 999) / 1000;
    if (cyc < 1) begin
      cyc = 1;
    end
    return cyc;
  endfunction

  // filter code to time; code 6 has no own figure and repeats 300 ns
  function automatic int filt_code_ns(input csw_pkg::csw_filt_code_t code);
    int ns;
    unique case (code)
      3'h6:    ns = `CSW_DOM_CODE6_NS;
      3'h7:    ns = `CSW_DOM_MAX_NS;
      default: ns = (int'(code) + 1) * `CSW_DOM_STEP_NS;
    endcase
    return ns;
  endfunction

  // one address compare shared by every write strobe and kept in one place
  function automatic logic hit(input csw_pkg::csw_addr_t a, input csw_pkg::csw_addr_t r);
    return a == r;
  endfunction

  // the longest filter time must fit the counter; a narrower counter would
  // saturate early and let a long dominant pulse pass as a short one
  if (ns_to_cycles(`CSW_DOM_MAX_NS) >= (1 << CNT_W)) begin : g_cnt_check
    $error("csw_config: CNT_W too small for the longest dominant filter time");
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage and decode
  // flip-flops first, then the strobes that load them

  csw_pkg::csw_byte_t payload [4];
  logic               fd_err_dis;
  logic               fd_bypass;
  logic [2:0]         fd_filt;
  logic               fd_en;
  logic               trim_preset;
  logic [6:0]         trim_val;
  logic               opt_rx_sel;
  logic [4:0]         opt_preset;
  csw_pkg::csw_byte_t osc_cal_high;
  logic               key_open;
  logic               wr_fd;
  logic               wr_trim;
  logic               wr_opt;
  logic [3:0]         wr_payload;
  csw_pkg::csw_byte_t next_rdata;

  // write strobes; the key is a level, sampled together with the strobe
  assign key_open = (trim_enable == `CSW_TRIM_KEY);
  assign wr_fd    = reg_wr_en && hit(reg_addr, `CSW_ADDR_FD_CTRL);
  assign wr_trim  = reg_wr_en && hit(reg_addr, `CSW_ADDR_OSC_TRIM);
  assign wr_opt   = reg_wr_en && hit(reg_addr, `CSW_ADDR_WAKE_OPT);

  // payload index 3 sits at the lowest address
  // one strobe per byte, at most one of them high
  always_comb begin
    wr_payload    = 4'h0;
    wr_payload[3] = reg_wr_en && hit(reg_addr, `CSW_ADDR_PAYLOAD_3);
    wr_payload[2] = reg_wr_en && hit(reg_addr, `CSW_ADDR_PAYLOAD_2);
    wr_payload[1] = reg_wr_en && hit(reg_addr, `CSW_ADDR_PAYLOAD_1);
    wr_payload[0] = reg_wr_en && hit(reg_addr, `CSW_ADDR_PAYLOAD_0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // payload bytes; restart keeps them as they are
  // a write that meets restart is dropped, not held back for later
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) begin
        payload[i] <= `CSW_PAYLOAD_RESET;
      end
    end else if (soft_reset) begin
      for (int i = 0; i < 4; i++) begin
        payload[i] <= `CSW_PAYLOAD_RESET;
      end
    end else if (!restart) begin
      for (int i = 0; i < 4; i++) begin
        if (wr_payload[i]) begin
          payload[i] <= reg_wdata;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fd control plain fields 4:0; bits 7:6 are not stored, a restart leaves 4:0
  // as they were and the reserved pair always reads back as zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fd_bypass <= 1'(`CSW_FD_CTRL_RESET >> `CSW_FD_BYPASS_BIT);
      fd_filt   <= 3'h0;
      fd_en     <= 1'b0;
    end else if (soft_reset) begin
      fd_bypass <= 1'b0;
      fd_filt   <= 3'h0;
      fd_en     <= 1'b0;
    end else if (wr_fd && !restart) begin
      fd_bypass <= reg_wdata[`CSW_FD_BYPASS_BIT];
      fd_filt   <= reg_wdata[`CSW_FD_FILT_HI:`CSW_FD_FILT_LO];
      fd_en     <= reg_wdata[`CSW_FD_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error counter disable: software writes it, silence timeout clears it;
  // the hardware clear wins so a stale write cannot outlive a bus silence
  // the clear acts in restart too, since it is not a software write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fd_err_dis <= 1'b0;
    end else if (soft_reset || silence_timeout) begin
      fd_err_dis <= 1'b0;
    end else if (wr_fd && !restart) begin
      fd_err_dis <= reg_wdata[`CSW_FD_ERR_DIS_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator trim: value key-guarded, preset bit stored as written
  // software normally leaves the trim alone; clock recovery covers drift
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trim_preset <= 1'(`CSW_OSC_TRIM_RESET >> `CSW_TRIM_PRESET_BIT);
      trim_val    <= 7'(`CSW_OSC_TRIM_RESET);
    end else if (soft_reset) begin
      trim_preset <= 1'(`CSW_OSC_TRIM_RESET >> `CSW_TRIM_PRESET_BIT);
      trim_val    <= 7'(`CSW_OSC_TRIM_RESET);
    end else if (wr_trim && !restart) begin
      trim_preset <= reg_wdata[`CSW_TRIM_PRESET_BIT];
      if (key_open) begin
        trim_val <= reg_wdata[`CSW_TRIM_VAL_HI:`CSW_TRIM_VAL_LO];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake options: bit 7 key-guarded, bits 6:5 not stored, 4:0 kept over restart
  // the key guards bit 7 only, so 4:0 take a write whatever the key says
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      opt_rx_sel <= 1'b0;
      opt_preset <= `CSW_OPT_PRESET_RESET;
    end else if (soft_reset) begin
      opt_rx_sel <= 1'b0;
      opt_preset <= `CSW_OPT_PRESET_RESET;
    end else if (wr_opt && !restart) begin
      if (key_open) begin
        opt_rx_sel <= reg_wdata[`CSW_OPT_RX_SEL_BIT];
      end
      opt_preset <= reg_wdata[`CSW_OPT_PRESET_HI:`CSW_OPT_PRESET_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // calibration high byte follows the oscillator, restart keeps last value
  // software writes never reach it, the register port only reads it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_cal_high <= `CSW_OSC_CAL_RESET;
    end else if (soft_reset) begin
      osc_cal_high <= `CSW_OSC_CAL_RESET;
    end else if (!restart) begin
      osc_cal_high <= osc_cal_high_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; reserved bits and unmapped addresses return zero
  // reads have no side effect, so they stay open during restart
  always_comb begin
    next_rdata = `CSW_UNMAPPED_READ;
    unique case (reg_addr)
      `CSW_ADDR_PAYLOAD_3:    next_rdata = payload[3];
      `CSW_ADDR_PAYLOAD_2:    next_rdata = payload[2];
      `CSW_ADDR_PAYLOAD_1:    next_rdata = payload[1];
      `CSW_ADDR_PAYLOAD_0:    next_rdata = payload[0];
      `CSW_ADDR_FD_CTRL:      next_rdata = {2'h0, fd_err_dis, fd_bypass, fd_filt, fd_en};
      `CSW_ADDR_OSC_TRIM:     next_rdata = {trim_preset, trim_val};
      `CSW_ADDR_WAKE_OPT:     next_rdata = {opt_rx_sel, 2'h0, opt_preset};
      `CSW_ADDR_OSC_CAL_HIGH: next_rdata = osc_cal_high;
      default:                next_rdata = `CSW_UNMAPPED_READ;
    endcase
  end

  // read data held until the next read; the valid flag marks the one cycle
  // in which a fresh answer stands
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata    <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive path: analog stage optional, digital filter always after it
  // the bypass only picks the source; nothing here can skip the digital stage
  csw_rx_if #(.CNT_W(CNT_W)) rx_bus ();

  assign rx_bus.rx_selected = fd_bypass ? rx_raw : rx_analog_filtered;
  assign rx_bus.filt_cycles = CNT_W'(ns_to_cycles(filt_code_ns(fd_filt)));

  csw_dom_filter #(.CNT_W(CNT_W)) u_dom_filter (
    .clk     (clk),
    .reset_n (reset_n),
    .rx      (rx_bus)
  );

  // the filter output is already a flip-flop, so rx_out needs no extra stage
  // and a new filter code takes hold on the next low sample
  assign rx_out = rx_bus.rx_filtered;

  ////////////////////////////////////////////////////////////////////////////
  // configuration outputs from the storage flip-flops; filter cycles and counter run are decoded from them

  // payload bytes in the order of their register numbers
  assign payload_byte_three      = payload[3];
  assign payload_byte_two        = payload[2];
  assign payload_byte_one        = payload[1];
  assign payload_byte_zero       = payload[0];

  // fd tolerance fields and the filter time they select
  assign fd_tolerant_enable      = fd_en;
  assign error_counter_disable   = fd_err_dis;
  assign analog_rx_filter_bypass = fd_bypass;
  assign dominant_filter_time    = fd_filt;
  assign dominant_filter_cycles  = rx_bus.filt_cycles;

  // trim value and receiver select
  assign oscillator_trim_value   = trim_val;
  // software must pick the standard receiver for fd above 1 Mbit/s
  assign wake_receiver_select    = opt_rx_sel;

  // counter halts only during wake with both fd tolerance and disable set
  // outside selective wake the disable bit has no effect at all
  assign error_counter_run = !(selective_wake_active && fd_en && fd_err_dis);

endmodule

/* core/csw_defs.svh */
// register offsets, field positions, reset values and timing figures of the wake config block
`ifndef CSW_DEFS_SVH
`define CSW_DEFS_SVH

// register addresses on the serial register port, 7 bits
`define CSW_ADDR_PAYLOAD_3     7'h30
`define CSW_ADDR_PAYLOAD_2     7'h31
`define CSW_ADDR_PAYLOAD_1     7'h32
`define CSW_ADDR_PAYLOAD_0     7'h33
`define CSW_ADDR_FD_CTRL       7'h34
`define CSW_ADDR_OSC_TRIM      7'h38
`define CSW_ADDR_WAKE_OPT      7'h39
`define CSW_ADDR_OSC_CAL_HIGH  7'h3a

// fd tolerance control fields
`define CSW_FD_RSVD_HI         7
`define CSW_FD_RSVD_LO         6
`define CSW_FD_ERR_DIS_BIT     5
`define CSW_FD_BYPASS_BIT      4
`define CSW_FD_FILT_HI         3
`define CSW_FD_FILT_LO         1
`define CSW_FD_EN_BIT          0

// oscillator trim fields
`define CSW_TRIM_PRESET_BIT    7
`define CSW_TRIM_VAL_HI        6
`define CSW_TRIM_VAL_LO        0

// wake options fields
`define CSW_OPT_RX_SEL_BIT     7
`define CSW_OPT_RSVD_HI        6
`define CSW_OPT_RSVD_LO        5
`define CSW_OPT_PRESET_HI      4
`define CSW_OPT_PRESET_LO      0

// trim protection key
`define CSW_TRIM_KEY           2'h3

// reset values
`define CSW_PAYLOAD_RESET      8'h00
`define CSW_FD_CTRL_RESET      8'h00
`define CSW_OSC_TRIM_RESET     8'h40
`define CSW_OPT_PRESET_RESET   5'h00
`define CSW_OSC_CAL_RESET      8'h00
`define CSW_UNMAPPED_READ      8'h00

// dominant filter times in ns and clock rate in MHz
`define CSW_CLK_MHZ            250
`define CSW_DOM_STEP_NS        50
`define CSW_DOM_CODE6_NS       300
`define CSW_DOM_MAX_NS         700

`endif

/* core/csw_pkg.sv */
// types shared by the wake config block
package csw_pkg;

  typedef logic [6:0] csw_addr_t;
  typedef logic [7:0] csw_byte_t;
  typedef logic [2:0] csw_filt_code_t;

  // dominant filter output state, one bit so adjacent codes differ in one bit
  typedef enum logic {
    CSW_REC = 1'b0,
    CSW_DOM = 1'b1
  } csw_filt_state_t;

endpackage

/* core/csw_rx_if.sv */
// receive path carrier between the config top and its dominant filter
`timescale 1ns/10ps
interface csw_rx_if #(
  parameter int CNT_W = 8
);
  logic             rx_selected;
  logic [CNT_W-1:0] filt_cycles;
  logic             rx_filtered;

  modport ctrl (output rx_selected, output filt_cycles, input rx_filtered);
  modport filt (input rx_selected, input filt_cycles, output rx_filtered);
endinterface

/* core/csw_dom_filter.sv */
// digital dominant pulse filter on the selected receive path
`timescale 1ns/10ps
module csw_dom_filter #(
  parameter int CNT_W = 8
) (
  input  wire logic clk,
  input  wire logic reset_n,
  csw_rx_if.filt    rx
);

  csw_pkg::csw_filt_state_t state;
  logic [CNT_W-1:0]         low_cnt;
  logic [CNT_W-1:0]         next_low_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // count consecutive dominant (low) samples, saturating
  always_comb begin
    next_low_cnt = low_cnt;
    if (rx.rx_selected) begin
      next_low_cnt = '0;
    end else if (low_cnt != {CNT_W{1'b1}}) begin
      next_low_cnt = low_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt <= '0;
    end else begin
      low_cnt <= next_low_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dominant passes only after the full filter time; recessive passes at once
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= csw_pkg::CSW_REC;
    end else begin
      unique case (state)
        csw_pkg::CSW_REC: begin
          if (!rx.rx_selected && next_low_cnt >= rx.filt_cycles) begin
            state <= csw_pkg::CSW_DOM;
          end
        end
        csw_pkg::CSW_DOM: begin
          if (rx.rx_selected) begin
            state <= csw_pkg::CSW_REC;
          end
        end
      endcase
    end
  end

  assign rx.rx_filtered = (state == csw_pkg::CSW_REC);

endmodule

/* sim/csw_config_assertions.sv */
// concurrent checks on the ports of the wake config block
`timescale 1ns/10ps
`include "csw_defs.svh"
module csw_config_assertions #(
  parameter int CNT_W = 8
) (
  input wire logic               clk,
  input wire logic               reset_n,
  input wire logic               soft_reset,
  input wire logic               restart,
  input wire logic               reg_wr_en,
  input wire logic               reg_rd_en,
  input wire csw_pkg::csw_addr_t reg_addr,
  input wire csw_pkg::csw_byte_t reg_wdata,
  input wire csw_pkg::csw_byte_t reg_rdata,
  input wire logic               reg_rd_valid,
  input wire logic [1:0]         trim_enable,
  input wire logic               silence_timeout,
  input wire logic               selective_wake_active,
  input wire csw_pkg::csw_byte_t payload_byte_zero,
  input wire logic               fd_tolerant_enable,
  input wire logic               error_counter_disable,
  input wire logic               error_counter_run,
  input wire logic [2:0]         dominant_filter_time,
  input wire logic [CNT_W-1:0]   dominant_filter_cycles,
  input wire logic [6:0]         oscillator_trim_value,
  input wire logic               wake_receiver_select
);
  // filter lengths in clocks, rounded up so no short pulse slips through
  localparam int CYC[8] = '{13, 25, 38, 50, 63, 75, 75, 175};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  a_read_answer: assert property (reg_rd_valid == $past(reg_rd_en))
    else $error("read answer not one cycle after strobe");
  a_fd_rsvd_zero: assert property (reg_rd_en && reg_addr == `CSW_ADDR_FD_CTRL
    |=> reg_rdata[7:6] == 2'h0) else $error("fd reserved bits not zero");
  a_err_cnt_run: assert property (error_counter_run ==
    !(selective_wake_active && fd_tolerant_enable && error_counter_disable))
    else $error("error counter run wrong");
  a_silence_clear: assert property (silence_timeout && !restart |=> !error_counter_disable)
    else $error("silence timeout did not clear disable bit");
  a_payload_write: assert property (reg_wr_en && reg_addr == `CSW_ADDR_PAYLOAD_0 &&
    !soft_reset && !restart |=> payload_byte_zero == $past(reg_wdata))
    else $error("payload byte zero not written");
  a_filter_cycles: assert property
    (dominant_filter_cycles == CNT_W'(CYC[dominant_filter_time]))
    else $error("filter cycles do not match code");
  a_trim_locked: assert property (reg_wr_en && reg_addr == `CSW_ADDR_OSC_TRIM &&
    trim_enable != `CSW_TRIM_KEY && !soft_reset |=> $stable(oscillator_trim_value))
    else $error("trim changed while locked");
  a_rx_sel_locked: assert property (reg_wr_en && reg_addr == `CSW_ADDR_WAKE_OPT &&
    trim_enable != `CSW_TRIM_KEY && !soft_reset |=> $stable(wake_receiver_select))
    else $error("receiver select changed while locked");
  a_soft_clear: assert property (soft_reset |=> payload_byte_zero == 8'h00 &&
    !fd_tolerant_enable && !wake_receiver_select) else $error("soft reset left state");
  a_restart_hold: assert property (restart && !soft_reset |=> $stable(payload_byte_zero)
    && $stable(fd_tolerant_enable)) else $error("restart changed stored bits");
endmodule

bind csw_config csw_config_assertions #(.CNT_W(CNT_W)) u_chk (.clk, .reset_n, .soft_reset,
  .restart, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid,
  .trim_enable, .silence_timeout, .selective_wake_active, .payload_byte_zero,
  .fd_tolerant_enable, .error_counter_disable, .error_counter_run, .dominant_filter_time,
  .dominant_filter_cycles, .oscillator_trim_value, .wake_receiver_select);

/* sim/csw_host.sv */
// host side model issuing register accesses on the serial register port
`timescale 1ns/10ps
`include "csw_defs.svh"
module csw_host (
  input  wire logic         clk,
  output logic               wr_en,
  output logic               rd_en,
  output csw_pkg::csw_addr_t addr,
  output csw_pkg::csw_byte_t wdata
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 7'h00;
    wdata = 8'h00;
  end

  // strobes last one cycle, then one idle cycle so no pin is set twice at once
  task automatic wr(input csw_pkg::csw_addr_t a, input csw_pkg::csw_byte_t d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask

  task automatic rd(input csw_pkg::csw_addr_t a);
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
  endtask

  // top bit kept at its preset, and the trim is written only on test need
  task automatic trim(input logic [6:0] t);
    wr(`CSW_ADDR_OSC_TRIM, {1'b0, t});
  endtask

  // standard receiver picked before fd tolerant use at high rates
  task automatic std_rx();
    wr(`CSW_ADDR_WAKE_OPT, 8'h80);
  endtask
endmodule

/* sim/csw_config_bench.sv */
// self-checking bench of the wake config block
`timescale 1ns/10ps
`include "csw_defs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module csw_config_bench;
  logic               clk, reset_n, soft_reset, restart, silence_timeout;
  logic               selective_wake_active, rx_raw, rx_analog_filtered, rx_out;
  logic               reg_wr_en, reg_rd_en, reg_rd_valid, error_counter_run;
  logic               fd_tolerant_enable, error_counter_disable, analog_rx_filter_bypass;
  logic               wake_receiver_select;
  logic [1:0]         trim_enable;
  logic [6:0]         oscillator_trim_value;
  logic [7:0]         dominant_filter_cycles;
  csw_pkg::csw_addr_t reg_addr;
  csw_pkg::csw_addr_t adr[9];
  csw_pkg::csw_byte_t reg_wdata, reg_rdata, cal, exp_v, payload_byte_three, payload_byte_zero;
  csw_pkg::csw_byte_t payload_byte_two, payload_byte_one;
  csw_pkg::csw_byte_t v[4];
  csw_pkg::csw_byte_t rst[9];
  csw_pkg::csw_byte_t q[$];
  int                 n_errors = 0, n_compared = 0, n;
  int                 cyc[8] = '{13, 25, 38, 50, 63, 75, 75, 175};

  csw_host h (.clk, .wr_en(reg_wr_en), .rd_en(reg_rd_en), .addr(reg_addr), .wdata(reg_wdata));
  csw_config #(.CNT_W(8)) dut (.clk, .reset_n, .soft_reset, .restart, .reg_wr_en, .reg_rd_en,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid, .trim_enable, .silence_timeout,
    .selective_wake_active, .osc_cal_high_in(cal), .rx_raw, .rx_analog_filtered, .rx_out,
    .payload_byte_three, .payload_byte_two, .payload_byte_one, .payload_byte_zero,
    .fd_tolerant_enable, .error_counter_disable, .error_counter_run, .analog_rx_filter_bypass,
    .dominant_filter_time(), .dominant_filter_cycles, .oscillator_trim_value,
    .wake_receiver_select);

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // read answers are matched against notes in issue order
  always @(negedge clk) begin
    if (reg_rd_valid === 1'b1) begin
      exp_v = q.pop_front();
      `CHK("reg_rdata", exp_v, reg_rdata)
    end
  end

  task automatic rd_exp(input csw_pkg::csw_addr_t a, input csw_pkg::csw_byte_t e);
    q.push_back(e);
    h.rd(a);
  endtask

  task automatic pulse_low();
    @(negedge clk);
  endtask

  task automatic conclude();
    if (n_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog well past the 130 or so cycles the sequence needs
  initial begin
    #100000;
    n_errors++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    n = $urandom(32'h959e);
    {reset_n, soft_reset, restart, silence_timeout, selective_wake_active} = 5'h00;
    {rx_raw, rx_analog_filtered} = 2'h3;
    trim_enable = 2'h0;
    cal = csw_pkg::csw_byte_t'($urandom);
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    // reset values of every register and one unmapped place
    adr = '{7'h30, 7'h31, 7'h32, 7'h33, 7'h34, 7'h38, 7'h39, 7'h3a, 7'h35};
    rst = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, `CSW_OSC_TRIM_RESET, 8'h00, cal, 8'h00};
    foreach (adr[i]) rd_exp(adr[i], rst[i]);
    // payload bytes, random contents
    foreach (v[i]) begin
      v[i] = csw_pkg::csw_byte_t'($urandom);
      h.wr(csw_pkg::csw_addr_t'(`CSW_ADDR_PAYLOAD_3 + i), v[i]);
    end
    `CHK("payload_byte_three", v[0], payload_byte_three)
    `CHK("payload_byte_zero", v[3], payload_byte_zero)
    `CHK("payload_byte_two", v[1], payload_byte_two)
    `CHK("payload_byte_one", v[2], payload_byte_one)
    foreach (v[i]) rd_exp(csw_pkg::csw_addr_t'(`CSW_ADDR_PAYLOAD_3 + i), v[i]);
    // fd control: reserved bits, counter stop and its hardware clear
    selective_wake_active = 1'b1;
    h.wr(`CSW_ADDR_FD_CTRL, 8'hff);
    rd_exp(`CSW_ADDR_FD_CTRL, 8'h3f);
    `CHK("error_counter_run", 1'b0, error_counter_run)
    `CHK("fd_tolerant_enable", 1'b1, fd_tolerant_enable)
    `CHK("analog_rx_filter_bypass", 1'b1, analog_rx_filter_bypass)
    silence_timeout = 1'b1;
    @(negedge clk);
    silence_timeout = 1'b0;
    `CHK("error_counter_disable", 1'b0, error_counter_disable)
    `CHK("error_counter_run", 1'b1, error_counter_run)
    h.wr(`CSW_ADDR_FD_CTRL, 8'h20);
    `CHK("error_counter_run", 1'b1, error_counter_run)
    for (int c = 0; c < 8; c++) begin
      h.wr(`CSW_ADDR_FD_CTRL, {4'h0, 3'(c), 1'b0});
      `CHK("dominant_filter_cycles", 8'(cyc[c]), dominant_filter_cycles)
    end
    // trim and receiver select behind the key
    h.trim(7'h7f);
    rd_exp(`CSW_ADDR_OSC_TRIM, `CSW_OSC_TRIM_RESET);
    h.wr(`CSW_ADDR_WAKE_OPT, 8'hff);
    rd_exp(`CSW_ADDR_WAKE_OPT, 8'h1f);
    trim_enable = `CSW_TRIM_KEY;
    h.trim(7'h15);
    `CHK("oscillator_trim_value", 7'h15, oscillator_trim_value)
    h.std_rx();
    rd_exp(`CSW_ADDR_WAKE_OPT, 8'h80);
    `CHK("wake_receiver_select", 1'b1, wake_receiver_select)
    h.wr(`CSW_ADDR_OSC_CAL_HIGH, ~cal);
    rd_exp(`CSW_ADDR_OSC_CAL_HIGH, cal);
    // restart keeps stored values and ignores writes
    restart = 1'b1;
    h.wr(`CSW_ADDR_PAYLOAD_3, ~v[0]);
    rd_exp(`CSW_ADDR_FD_CTRL, 8'h0e);
    restart = 1'b0;
    rd_exp(`CSW_ADDR_PAYLOAD_3, v[0]);
    rd_exp(`CSW_ADDR_WAKE_OPT, 8'h80);
    // bypassed path: dominant must last 13 clocks, digital filter stays in
    h.wr(`CSW_ADDR_FD_CTRL, 8'h10);
    rx_raw = 1'b0;
    repeat (12) @(negedge clk);
    `CHK("rx_out", 1'b1, rx_out)
    @(negedge clk);
    `CHK("rx_out", 1'b0, rx_out)
    h.wr(`CSW_ADDR_FD_CTRL, 8'h00);
    @(negedge clk);
    `CHK("rx_out", 1'b1, rx_out)
    rx_raw = 1'b1;
    // filtered path in use: its dominant passes the same digital filter
    rx_analog_filtered = 1'b0;
    repeat (13) @(negedge clk);
    `CHK("rx_out", 1'b0, rx_out)
    rx_analog_filtered = 1'b1;
    @(negedge clk);
    `CHK("rx_out", 1'b1, rx_out)
    // soft reset returns power-on values
    soft_reset = 1'b1;
    @(negedge clk);
    soft_reset = 1'b0;
    rd_exp(`CSW_ADDR_PAYLOAD_3, 8'h00);
    rd_exp(`CSW_ADDR_OSC_TRIM, `CSW_OSC_TRIM_RESET);
    rd_exp(`CSW_ADDR_WAKE_OPT, 8'h00);
    repeat (4) @(negedge clk);
    conclude();
  end
endmodule
